// ==== ecap_regs.svh ====
// Operation
// - In capture mode the first timer count is recorded when the selected edge arrives on the event input pin.
// - In compare mode a match of the first timer with the programmed value fires a visible event.
// - In PWM mode the output period and duty cycle are both set by software.
// - Capture and compare run on the first timer, PWM runs on the second timer.
// - A capture copies all sixteen bits of the first timer into the result high and low registers.
// - Each capture sets the capture/compare flag, which stays set until software clears it.
// - A new capture overwrites the earlier result even if it was never read.
// - The capture prescaler counter is cleared when the unit is off, not in capture mode, or in reset.
`ifndef ECAP_REGS_SVH
`define ECAP_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ECAP_A_CTRL 4'h0
`define ECAP_A_RES_LO 4'h1
`define ECAP_A_RES_HI 4'h2
`define ECAP_A_PERIOD 4'h3
`define ECAP_A_DUTY_HI 4'h4
`define ECAP_A_STATUS 4'h5
`define ECAP_A_INT_CLR 4'h6
`define ECAP_A_INT_EN 4'h7
`define ECAP_A_T1_LO 4'h8
`define ECAP_A_T1_HI 4'h9
`define ECAP_A_T2 4'hA
`define ECAP_A_DEAD 4'hB

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define ECAP_STEER 7:6
`define ECAP_DUTY_LO 5:4
`define ECAP_MODE 3:0
`define ECAP_MODE_CLASS 3:2
`define ECAP_PWM_CLASS 2'h3
`define ECAP_POL_AC 1
`define ECAP_POL_BD 0
`define ECAP_FLG_CC 0
`define ECAP_FLG_PER 1
`define ECAP_R8_RST 8'h00
`define ECAP_R16_RST 16'h0000
`define ECAP_R10_RST 10'h000
`define ECAP_R2_RST 2'h0
`define ECAP_FINE_LAST 2'h3
`define ECAP_DIV4_LAST 4'h3
`define ECAP_DIV16_LAST 4'hF
`define ECAP_ST_SINGLE 2'h0
`define ECAP_ST_FWD 2'h1
`define ECAP_ST_HALF 2'h2
`define ECAP_ST_REV 2'h3

`endif

// ==== ecap_pkg.sv ====
`default_nettype none

package ecap_pkg;
  // Unit mode codes, reserved codes are absent
  typedef enum logic [3:0] {
    ECAP_M_OFF = 4'h0,
    ECAP_M_CMP_TGL = 4'h2,
    ECAP_M_CAP_FALL = 4'h4,
    ECAP_M_CAP_RISE = 4'h5,
    ECAP_M_CAP_4 = 4'h6,
    ECAP_M_CAP_16 = 4'h7,
    ECAP_M_CMP_SET = 4'h8,
    ECAP_M_CMP_CLR = 4'h9,
    ECAP_M_CMP_SWI = 4'hA,
    ECAP_M_CMP_SPE = 4'hB,
    ECAP_M_PWM_HH = 4'hC,
    ECAP_M_PWM_HL = 4'hD,
    ECAP_M_PWM_LH = 4'hE,
    ECAP_M_PWM_LL = 4'hF
  } ecap_mode_e;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ecap_bus_s;

  // Four bridge pins
  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } ecap_pins_s;
endpackage

`default_nettype wire

// ==== ecap_presc.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ecap_regs.svh"

module ecap_presc (
  input wire logic core_clk_i, // Core clock
  input wire logic rst_i, // Synchronous reset
  input wire logic clr_i, // Hold counter at zero
  input wire logic rise_i, // Rising edge seen
  input wire logic div16_i, // 1: every 16th, 0: every 4th
  output logic tick_o, // Prescaled event
  output logic [3:0] count_o // Counter value
);
  logic [3:0] cnt_q, cnt_d;
  logic [3:0] last;

  // ----------------------------------------------------------------
  // Edge counter
  // ----------------------------------------------------------------
  // Terminal count and next value
  always_comb begin
    last = div16_i ? `ECAP_DIV16_LAST : `ECAP_DIV4_LAST;
    tick_o = rise_i && !clr_i && (cnt_q == last);
    cnt_d = cnt_q;
    if (clr_i) begin
      cnt_d = 4'h0;
    end else if (rise_i) begin
      cnt_d = tick_o ? 4'h0 : cnt_q + 4'h1;
    end
  end

  // Counter register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign count_o = cnt_q;
endmodule
`default_nettype wire

// ==== ecap_top.sv ====
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "ecap_regs.svh"

module ecap_top (
  input wire logic core_clk_i, // Core clock, 100 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire ecap_pkg::ecap_bus_s bus_i, // Register request
  output logic [7:0] rdata_o, // Read data, cycle after read
  input wire logic event_pin_i, // Event input pin level
  output ecap_pkg::ecap_pins_s pins_o, // Bridge output levels
  output ecap_pkg::ecap_pins_s pins_oe_o, // Bridge output enables
  output logic irq_o // Level interrupt
);
  import ecap_pkg::*;

  logic [7:0] ctrl_q, ctrl_d, per_q, per_d, dhi_q, dhi_d, dead_q, dead_d;
  logic [7:0] dcnt_q, dcnt_d, rdata_q, rdata_d;
  logic [15:0] res_q, res_d, t1_q, t1_d;
  logic [9:0] t2_q, t2_d, dlat_q, dlat_d;
  logic [1:0] sts_q, sts_d, ien_q, ien_d;
  logic out_q, out_d, pin_prev_q, pwm_prev_q, pwm_raw;
  ecap_pins_s pins_q, pins_d, oe_q, oe_d;
  ecap_mode_e mode;
  logic rise, fall, tick, cap_mode, cmp_mode, pwm_mode, cap_evt, match, per_evt;
  logic lvl_ac, lvl_bd, half_a, half_b;
  logic [3:0] presc_cnt;

  // ----------------------------------------------------------------
  // Mode decode and edge detect
  // ----------------------------------------------------------------
  // Classify the control mode field
  always_comb begin
    mode = ecap_mode_e'(ctrl_q[`ECAP_MODE]);
    cap_mode = 1'b0;
    cmp_mode = 1'b0;
    pwm_mode = 1'b0;
    unique case (mode)
      ECAP_M_CAP_FALL, ECAP_M_CAP_RISE, ECAP_M_CAP_4, ECAP_M_CAP_16: cap_mode = 1'b1;
      ECAP_M_CMP_TGL, ECAP_M_CMP_SET, ECAP_M_CMP_CLR, ECAP_M_CMP_SWI,
      ECAP_M_CMP_SPE: cmp_mode = 1'b1;
      ECAP_M_PWM_HH, ECAP_M_PWM_HL, ECAP_M_PWM_LH, ECAP_M_PWM_LL: pwm_mode = 1'b1;
      default: begin
        cap_mode = 1'b0; // Off or reserved code
      end
    endcase
  end

  assign rise = event_pin_i && !pin_prev_q;
  assign fall = !event_pin_i && pin_prev_q;

  // Prescaler for every 4th and 16th rising edge
  ecap_presc u_presc (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .clr_i(!cap_mode),
    .rise_i(rise),
    .div16_i(mode == ECAP_M_CAP_16),
    .tick_o(tick),
    .count_o(presc_cnt)
  );

  // Capture event per selected edge
  always_comb begin
    cap_evt = 1'b0;
    if (mode == ECAP_M_CAP_FALL) begin
      cap_evt = fall;
    end else if (mode == ECAP_M_CAP_RISE) begin
      cap_evt = rise;
    end else if (cap_mode) begin
      cap_evt = tick;
    end
  end

  assign match = cmp_mode && (t1_q == res_q);
  assign per_evt = pwm_mode && (t2_q[9:2] == per_q) && (t2_q[1:0] == `ECAP_FINE_LAST);
  assign pwm_raw = pwm_mode && (t2_q < dlat_q);
  assign half_a = pwm_prev_q && (dcnt_q == `ECAP_R8_RST);
  assign half_b = !pwm_prev_q && (dcnt_q == `ECAP_R8_RST);
  assign lvl_ac = !ctrl_q[`ECAP_POL_AC];
  assign lvl_bd = !ctrl_q[`ECAP_POL_BD];

  // ----------------------------------------------------------------
  // Next state of registers, timers and pins
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    per_d = per_q;
    dhi_d = dhi_q;
    dead_d = dead_q;
    res_d = res_q;
    ien_d = ien_q;
    sts_d = sts_q;
    out_d = out_q;
    rdata_d = `ECAP_R8_RST;
    // Software writes
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        `ECAP_A_CTRL: ctrl_d = bus_i.wdata;
        `ECAP_A_RES_LO: res_d[7:0] = bus_i.wdata;
        `ECAP_A_RES_HI: res_d[15:8] = bus_i.wdata;
        `ECAP_A_PERIOD: per_d = bus_i.wdata;
        `ECAP_A_DUTY_HI: dhi_d = bus_i.wdata;
        `ECAP_A_INT_CLR: sts_d = sts_q & ~bus_i.wdata[1:0];
        `ECAP_A_INT_EN: ien_d = bus_i.wdata[1:0];
        `ECAP_A_DEAD: dead_d = bus_i.wdata;
        default: begin
          sts_d = sts_d; // Read-only or unmapped
        end
      endcase
    end
    // Capture overwrites any earlier result
    if (cap_evt) begin
      res_d = t1_q;
      sts_d[`ECAP_FLG_CC] = 1'b1;
    end
    // Compare match actions
    if (match) begin
      sts_d[`ECAP_FLG_CC] = 1'b1;
      if (mode == ECAP_M_CMP_TGL) begin
        out_d = !out_q;
      end else if (mode == ECAP_M_CMP_SET) begin
        out_d = 1'b1;
      end else if (mode == ECAP_M_CMP_CLR) begin
        out_d = 1'b0;
      end
    end
    if (per_evt) begin
      sts_d[`ECAP_FLG_PER] = 1'b1;
    end
    // First timer, reset by special event match
    t1_d = (match && mode == ECAP_M_CMP_SPE) ? `ECAP_R16_RST : t1_q + 16'h0001;
    // Second timer with two fine bits, duty latched per period
    dlat_d = dlat_q;
    if (!pwm_mode) begin
      t2_d = `ECAP_R10_RST;
    end else if (per_evt) begin
      t2_d = `ECAP_R10_RST;
      dlat_d = {dhi_q, ctrl_q[`ECAP_DUTY_LO]};
    end else begin
      t2_d = t2_q + 10'h001;
    end
    // Dead band counter restarts on each modulator edge
    if (pwm_raw != pwm_prev_q) begin
      dcnt_d = dead_q;
    end else if (dcnt_q != `ECAP_R8_RST) begin
      dcnt_d = dcnt_q - 8'h01;
    end else begin
      dcnt_d = dcnt_q;
    end
    // Read mux
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        `ECAP_A_CTRL: rdata_d = ctrl_q;
        `ECAP_A_RES_LO: rdata_d = res_q[7:0];
        `ECAP_A_RES_HI: rdata_d = res_q[15:8];
        `ECAP_A_PERIOD: rdata_d = per_q;
        `ECAP_A_DUTY_HI: rdata_d = dhi_q;
        `ECAP_A_STATUS: rdata_d = {6'h00, sts_q};
        `ECAP_A_INT_EN: rdata_d = {6'h00, ien_q};
        `ECAP_A_T1_LO: rdata_d = t1_q[7:0];
        `ECAP_A_T1_HI: rdata_d = t1_q[15:8];
        `ECAP_A_T2: rdata_d = t2_q[9:2];
        `ECAP_A_DEAD: rdata_d = dead_q;
        default: rdata_d = `ECAP_R8_RST;
      endcase
    end
    // Output steering
    pins_d = '{a: 1'b0, b: 1'b0, c: 1'b0, d: 1'b0};
    oe_d = '{a: 1'b0, b: 1'b0, c: 1'b0, d: 1'b0};
    if (pwm_mode) begin
      unique case (ctrl_q[`ECAP_STEER])
        `ECAP_ST_SINGLE: begin
          pins_d.a = pwm_prev_q ~^ lvl_ac;
          oe_d.a = 1'b1;
        end
        `ECAP_ST_FWD: begin
          pins_d = '{a: lvl_ac, b: !lvl_bd, c: !lvl_ac, d: pwm_prev_q ~^ lvl_bd};
          oe_d = '{a: 1'b1, b: 1'b1, c: 1'b1, d: 1'b1};
        end
        `ECAP_ST_HALF: begin
          pins_d.a = half_a ~^ lvl_ac;
          pins_d.b = half_b ~^ lvl_bd;
          oe_d.a = 1'b1;
          oe_d.b = 1'b1;
        end
        default: begin
          pins_d = '{a: !lvl_ac, b: pwm_prev_q ~^ lvl_bd, c: lvl_ac, d: !lvl_bd};
          oe_d = '{a: 1'b1, b: 1'b1, c: 1'b1, d: 1'b1};
        end
      endcase
    end else if (mode == ECAP_M_CMP_TGL || mode == ECAP_M_CMP_SET || mode == ECAP_M_CMP_CLR) begin
      pins_d.a = out_q;
      oe_d.a = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_q <= `ECAP_R8_RST;
      per_q <= `ECAP_R8_RST;
      dhi_q <= `ECAP_R8_RST;
      dead_q <= `ECAP_R8_RST;
      dcnt_q <= `ECAP_R8_RST;
      rdata_q <= `ECAP_R8_RST;
      res_q <= `ECAP_R16_RST;
      t1_q <= `ECAP_R16_RST;
      t2_q <= `ECAP_R10_RST;
      dlat_q <= `ECAP_R10_RST;
      sts_q <= `ECAP_R2_RST;
      ien_q <= `ECAP_R2_RST;
      out_q <= 1'b0;
      pin_prev_q <= 1'b0;
      pwm_prev_q <= 1'b0;
      pins_q <= '{a: 1'b0, b: 1'b0, c: 1'b0, d: 1'b0};
      oe_q <= '{a: 1'b0, b: 1'b0, c: 1'b0, d: 1'b0};
    end else begin
      ctrl_q <= ctrl_d;
      per_q <= per_d;
      dhi_q <= dhi_d;
      dead_q <= dead_d;
      dcnt_q <= dcnt_d;
      rdata_q <= rdata_d;
      res_q <= res_d;
      t1_q <= t1_d;
      t2_q <= t2_d;
      dlat_q <= dlat_d;
      sts_q <= sts_d;
      ien_q <= ien_d;
      out_q <= out_d;
      pin_prev_q <= event_pin_i;
      pwm_prev_q <= pwm_raw;
      pins_q <= pins_d;
      oe_q <= oe_d;
    end
  end

  assign rdata_o = rdata_q;
  assign pins_o = pins_q;
  assign pins_oe_o = oe_q;
  assign irq_o = |(sts_q & ien_q);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  capture_value_a: assert property (cap_evt |=> res_q == $past(t1_q))
    else $error("capture result differs from timer");
  capture_flag_a: assert property (cap_evt |=> sts_q[0])
    else $error("capture did not set flag");
  flag_hold_a: assert property (sts_q[0] && !(bus_i.wr && bus_i.addr == `ECAP_A_INT_CLR)
    |=> sts_q[0])
    else $error("flag fell without clear");
  rise_capture_a: assert property (mode == ECAP_M_CAP_RISE && !event_pin_i ##1
    event_pin_i && $stable(ctrl_q) |-> cap_evt)
    else $error("rising edge not captured");
  compare_fire_a: assert property (cmp_mode && t1_q == res_q |=> sts_q[0])
    else $error("compare match without flag");
  compare_toggle_a: assert property (mode == ECAP_M_CMP_TGL && match ##1
    mode == ECAP_M_CMP_TGL |-> ##1 pins_o.a != $past(pins_o.a))
    else $error("toggle output did not flip");
  presc_clear_a: assert property (!cap_mode |=> presc_cnt == 4'h0)
    else $error("prescaler not cleared");
  pwm_timer_a: assert property (!pwm_mode |=> t2_q == `ECAP_R10_RST)
    else $error("second timer ran outside PWM mode");
  pwm_wrap_a: assert property (per_evt ##1 pwm_mode |-> t2_q == 10'h000)
    else $error("second timer missed period wrap");
  single_steer_a: assert property (pwm_mode && ctrl_q[7:6] == 2'h0 ##1 $stable(ctrl_q)
    |-> !pins_oe_o.b && !pins_oe_o.c && pins_oe_o.a)
    else $error("single output drives extra pins");
  overwrite_a: assert property (cap_evt && sts_q[0] |=> res_q == $past(t1_q))
    else $error("second capture not stored");

  capture_seen_c: cover property (cap_evt);
  compare_seen_c: cover property (match);
  period_seen_c: cover property (per_evt);
  half_bridge_c: cover property (pwm_mode && ctrl_q[7:6] == 2'h2 && half_b);
endmodule
`default_nettype wire

// ==== ecap_pin_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module ecap_pin_model (
  input wire logic core_clk_i, // Core clock
  input wire logic rst_i, // Synchronous reset
  input wire logic lvl_i, // Wanted event level
  input wire logic clr_i, // Restart load counters
  input wire ecap_pkg::ecap_pins_s pins_i, // Bridge levels
  input wire ecap_pkg::ecap_pins_s pins_oe_i, // Bridge enables
  output logic event_pin_o, // Event source line
  output logic [3:0][7:0] hi_cnt_o // Driven-high cycles, 3 is a, 0 is d
);
  import ecap_pkg::*;
  logic [3:0] hi_w;

  // Source line moves just after a clock edge, synchronous to the core
  always_ff @(posedge core_clk_i) begin
    event_pin_o <= rst_i ? 1'b0 : lvl_i;
  end

  // A load only sees a level while the pin is driven
  assign hi_w = {pins_i.a & pins_oe_i.a, pins_i.b & pins_oe_i.b,
                 pins_i.c & pins_oe_i.c, pins_i.d & pins_oe_i.d};

  // Loads count the cycles in which they are pulled high
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (rst_i || clr_i) begin
        hi_cnt_o[i] <= 8'h00;
      end else if (hi_w[i]) begin
        hi_cnt_o[i] <= hi_cnt_o[i] + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ecap_regs.svh"

module testbench;
  import ecap_pkg::*;
  logic core_clk_i;
  logic rst_i;
  ecap_bus_s bus;
  logic [7:0] rdata;
  logic ev_lvl;
  logic cnt_clr;
  logic event_pin;
  ecap_pins_s pins;
  ecap_pins_s pins_oe;
  logic irq;
  logic [3:0][7:0] hi_cnt;
  int bad_count;
  int checked;
  int cycles;
  logic [7:0] lo;
  logic [7:0] hi;
  logic [15:0] t0;
  logic [15:0] t1;
  logic [3:0] adr [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hB, 4'hC, 4'hF};
  logic [3:0] rwa [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'hB};
  logic [7:0] rwx [6] = '{8'hA5, 8'hA5, 8'hA5, 8'hA5, 8'h01, 8'hA5};
  logic [3:0] cmode [5] = '{4'h2, 4'h9, 4'h8, 4'hA, 4'hB};
  logic [1:0] cexp [5] = '{2'h3, 2'h2, 2'h3, 2'h0, 2'h0};
  logic [7:0] pctl [7] = '{8'h2C, 8'h6C, 8'hAC, 8'hEC, 8'h2F, 8'h6D, 8'hEE};
  logic [3:0] poe [7] = '{4'h8, 4'hF, 4'hC, 4'hF, 4'h8, 4'hF, 4'hF};
  logic [31:0] pcnt [7] = '{32'h0C000000, 32'h2000000C, 32'h0C140000, 32'h000C2000,
                            32'h14000000, 32'h20200014, 32'h200C0000};

  ecap_top i_dut (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .bus_i(bus),
    .rdata_o(rdata),
    .event_pin_i(event_pin),
    .pins_o(pins),
    .pins_oe_o(pins_oe),
    .irq_o(irq)
  );

  ecap_pin_model i_pins (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .lvl_i(ev_lvl),
    .clr_i(cnt_clr),
    .pins_i(pins),
    .pins_oe_i(pins_oe),
    .event_pin_o(event_pin),
    .hi_cnt_o(hi_cnt)
  );

  // 100 MHz core clock
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // Cut a hang short well past the expected run length
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge core_clk_i);
    bus.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge core_clk_i);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  // Each pulse takes exactly ten clock edges
  task automatic edges(input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      ev_lvl <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      ev_lvl <= 1'b0;
      repeat (6) @(posedge core_clk_i);
    end
  endtask

  // Timer is not latched, so a carry between byte reads is patched up
  task automatic rt(output logic [15:0] t);
    logic [7:0] h;
    logic [7:0] l;
    logic [7:0] h2;
    rd(`ECAP_A_T1_HI, h);
    rd(`ECAP_A_T1_LO, l);
    rd(`ECAP_A_T1_HI, h2);
    t = (h2 == h) ? {h, l} : {h2, 8'h00};
  endtask

  // Arm a compare 64 counts ahead, wait for the flag, then look at pin A
  task automatic cmp(input logic [3:0] m, input logic [1:0] exp);
    logic [15:0] t;
    int i;
    wr(`ECAP_A_CTRL, 8'h00);
    rt(t);
    t = t + 16'h0040;
    wr(`ECAP_A_RES_LO, t[7:0]);
    wr(`ECAP_A_RES_HI, t[15:8]);
    wr(`ECAP_A_CTRL, {4'h0, m});
    wr(`ECAP_A_INT_CLR, 8'h01);
    #1;
    i = 0;
    while (irq !== 1'b1 && i < 200) begin
      @(posedge core_clk_i);
      #1;
      i++;
    end
    chk({7'h00, irq}, 8'h01);
    repeat (3) @(posedge core_clk_i);
    #1;
    chk({6'h00, pins_oe.a, pins.a & pins_oe.a}, {6'h00, exp});
    if (m == 4'hB) begin
      rt(t);
      chk(t[15:8], 8'h00);
    end
  endtask

  initial begin
    bus = '0;
    ev_lvl = 1'b0;
    cnt_clr = 1'b0;
    rst_i = 1'b1;
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    // Reset values, write-only and unmapped places read zero
    foreach (adr[i]) rchk(adr[i], 8'h00);
    foreach (rwa[i]) begin
      wr(rwa[i], 8'hA5);
      rchk(rwa[i], rwx[i]);
      wr(rwa[i], 8'h00);
    end
    wr(`ECAP_A_CTRL, 8'hF0);
    rchk(`ECAP_A_CTRL, 8'hF0);
    wr(`ECAP_A_STATUS, 8'hFF);
    wr(`ECAP_A_CTRL, 8'h05);
    wr(`ECAP_A_INT_CLR, 8'h01);
    rchk(`ECAP_A_STATUS, 8'h00);
    wr(`ECAP_A_INT_EN, 8'h01);
    // Two rising captures exactly 300 cycles apart, first never cleared
    edges(1);
    rchk(`ECAP_A_STATUS, 8'h01);
    chk({7'h00, irq}, 8'h01);
    rd(`ECAP_A_RES_LO, t0[7:0]);
    rd(`ECAP_A_RES_HI, t0[15:8]);
    repeat (284) @(posedge core_clk_i);
    edges(1);
    rd(`ECAP_A_RES_LO, t1[7:0]);
    rd(`ECAP_A_RES_HI, t1[15:8]);
    t1 = t1 - t0;
    chk(t1[7:0], 8'h2C);
    chk(t1[15:8], 8'h01);
    rchk(`ECAP_A_STATUS, 8'h01);
    wr(`ECAP_A_INT_CLR, 8'h01);
    rchk(`ECAP_A_STATUS, 8'h00);
    chk({7'h00, irq}, 8'h00);
    // Falling-edge capture ignores the rise
    wr(`ECAP_A_CTRL, 8'h04);
    wr(`ECAP_A_INT_CLR, 8'h01);
    ev_lvl <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    rchk(`ECAP_A_STATUS, 8'h00);
    ev_lvl <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    rchk(`ECAP_A_STATUS, 8'h01);
    // Prescaler restarts after the unit is switched off
    wr(`ECAP_A_CTRL, 8'h00);
    wr(`ECAP_A_CTRL, 8'h06);
    edges(2);
    wr(`ECAP_A_CTRL, 8'h00);
    wr(`ECAP_A_CTRL, 8'h06);
    wr(`ECAP_A_INT_CLR, 8'h01);
    edges(3);
    rchk(`ECAP_A_STATUS, 8'h00);
    edges(1);
    rchk(`ECAP_A_STATUS, 8'h01);
    wr(`ECAP_A_CTRL, 8'h00);
    wr(`ECAP_A_CTRL, 8'h07);
    wr(`ECAP_A_INT_CLR, 8'h01);
    edges(15);
    rchk(`ECAP_A_STATUS, 8'h00);
    edges(1);
    rchk(`ECAP_A_STATUS, 8'h01);
    // Every compare mode in turn
    foreach (cmode[i]) cmp(cmode[i], cexp[i]);
    // PWM: period 16 cycles, duty 6, counted over two whole periods
    wr(`ECAP_A_CTRL, 8'h00);
    wr(`ECAP_A_PERIOD, 8'h03);
    wr(`ECAP_A_DUTY_HI, 8'h01);
    wr(`ECAP_A_INT_CLR, 8'h03);
    foreach (pctl[i]) begin
      wr(`ECAP_A_CTRL, pctl[i]);
      repeat (40) @(posedge core_clk_i);
      cnt_clr <= 1'b1;
      @(posedge core_clk_i);
      cnt_clr <= 1'b0;
      repeat (32) @(posedge core_clk_i);
      #1;
      chk({4'h0, pins_oe}, {4'h0, poe[i]});
      chk(hi_cnt[3], pcnt[i][31:24]);
      chk(hi_cnt[2], pcnt[i][23:16]);
      chk(hi_cnt[1], pcnt[i][15:8]);
      chk(hi_cnt[0], pcnt[i][7:0]);
    end
    // Dead band keeps the half-bridge pair from overlapping
    wr(`ECAP_A_DEAD, 8'h02);
    wr(`ECAP_A_CTRL, 8'hAC);
    lo = 8'h00;
    repeat (48) begin
      @(posedge core_clk_i);
      #1;
      lo = lo | {7'h00, pins.a & pins.b};
    end
    chk(lo, 8'h00);
    rd(`ECAP_A_T2, hi);
    chk({7'h00, hi <= 8'h03}, 8'h01);
    rchk(`ECAP_A_STATUS, 8'h02);
    chk({7'h00, irq}, 8'h00);
    wr(`ECAP_A_INT_EN, 8'h02);
    #1;
    chk({7'h00, irq}, 8'h01);
    wr(`ECAP_A_CTRL, 8'h00);
    wr(`ECAP_A_INT_CLR, 8'h03);
    rchk(`ECAP_A_STATUS, 8'h00);
    print_verdict();
  end
endmodule

`default_nettype wire
